// File: core/sbsp_fifo.sv
// capture fifo with registered output stage
`timescale 1ns/1ps
`include "sbsp_cfg.svh"
module sbsp_fifo #(
  parameter int W = `SBSP_DATA_W,
  parameter int DEPTH = `SBSP_FIFO_DEPTH,
  parameter int AW = `SBSP_FIFO_AW
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic in_valid_in,
  input wire logic [W-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [W-1:0] out_data_out,
  input wire logic out_ready_in
);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic [AW:0] count_nxt;
  logic in_ready_r;
  logic out_valid_r;
  logic [W-1:0] out_data_r;
  logic push;
  logic load;

  assign push = in_valid_in & in_ready_r;
  assign load = (count_r != '0) & (~out_valid_r | out_ready_in);

  always_comb begin
    count_nxt = count_r;
    if (push & ~load) begin
      count_nxt = count_r + (AW+1)'(1);
    end else if (~push & load) begin
      count_nxt = count_r - (AW+1)'(1);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      in_ready_r <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + AW'(1);
      end
      if (load) begin
        rd_ptr_r <= rd_ptr_r + AW'(1);
      end
      count_r <= count_nxt;
      // ready from the next count keeps full honest without a combinational path
      in_ready_r <= (count_nxt < (AW+1)'(DEPTH));
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      out_valid_r <= 1'b0;
      out_data_r <= '0;
    end else if (load) begin
      out_valid_r <= 1'b1;
      out_data_r <= mem[rd_ptr_r];
    end else if (out_ready_in) begin
      out_valid_r <= 1'b0;
    end
  end

  assign in_ready_out = in_ready_r;
  assign out_valid_out = out_valid_r;
  assign out_data_out = out_data_r;
endmodule : sbsp_fifo

// File: core/sbsp_port.sv
// pipelined single-cycle-deselect burst sram port, 512k x 36 with parity lanes
`timescale 1ns/1ps
`include "sbsp_cfg.svh"
module sbsp_port (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic [`SBSP_ADDR_W-1:0] addr_in,
  input wire logic [`SBSP_DATA_W-1:0] dq_in,
  output logic [`SBSP_DATA_W-1:0] dq_out,
  output logic dq_oe_out,
  input wire logic chip_select_n_in,
  input wire logic expansion_select_high_in,
  input wire logic expansion_select_low_n_in,
  input wire logic processor_addr_strobe_n_in,
  input wire logic controller_addr_strobe_n_in,
  input wire logic burst_advance_n_in,
  input wire logic lane_a_write_n_in,
  input wire logic lane_b_write_n_in,
  input wire logic lane_c_write_n_in,
  input wire logic lane_d_write_n_in,
  input wire logic lane_write_gate_n_in,
  input wire logic all_lanes_write_n_in,
  input wire logic output_enable_n_in,
  input wire logic snooze_request_in,
  input wire logic burst_order_select_in,
  output logic snooze_active_out,
  output logic capture_valid_out,
  output logic [`SBSP_DATA_W-1:0] capture_data_out,
  input wire logic capture_ready_in,
  output logic capture_ready_out
);
  sbsp_pkg::sbsp_cyc_t cyc_r;
  sbsp_pkg::sbsp_cyc_t cyc_nxt;
  logic active_r;
  logic active_nxt;
  logic [`SBSP_LO_W-1:0] base_lo_r;
  logic [`SBSP_LO_W-1:0] cnt_r;
  logic [`SBSP_LO_W-1:0] cnt_inc;
  logic load;
  logic step;
  logic sel_ok;
  logic linear;
  logic [`SBSP_LANES-1:0] wr_lanes;
  logic [`SBSP_DATA_W-1:0] mem [`SBSP_DEPTH];
  logic [`SBSP_DATA_W-1:0] rdata_r;
  logic drive_r;
  logic rd_done_r;
  logic snooze_r;

  // low address bits of the current burst beat
  function automatic logic [`SBSP_LO_W-1:0] burst_lo(
    input logic [`SBSP_LO_W-1:0] base,
    input logic [`SBSP_LO_W-1:0] cnt,
    input logic lin
  );
    burst_lo = lin ? (base + cnt) : (base ^ cnt);
  endfunction : burst_lo

  // lanes to write: global write wins, lane enables only behind the gate
  function automatic logic [`SBSP_LANES-1:0] lane_mask(
    input logic glob_n,
    input logic gate_n,
    input logic [`SBSP_LANES-1:0] lane_n
  );
    if (!glob_n) begin
      lane_mask = `SBSP_LANES_ALL;
    end else if (!gate_n) begin
      lane_mask = ~lane_n;
    end else begin
      lane_mask = `SBSP_LANES_NONE;
    end
  endfunction : lane_mask

  // order pin low is linear, high or floating interleaved; must stay static
  assign linear = ~burst_order_select_in;
  assign sel_ok = ~chip_select_n_in & expansion_select_high_in & ~expansion_select_low_n_in;
  assign wr_lanes = lane_mask(all_lanes_write_n_in, lane_write_gate_n_in,
                              {lane_d_write_n_in, lane_c_write_n_in, lane_b_write_n_in, lane_a_write_n_in});
  assign cnt_inc = cnt_r + `SBSP_CNT_ONE;

  // cycle decode from the inputs present at the coming rising edge
  always_comb begin
    load = 1'b0;
    step = 1'b0;
    active_nxt = active_r;
    cyc_nxt.op = sbsp_pkg::OP_IDLE;
    cyc_nxt.addr = cyc_r.addr;
    cyc_nxt.data = dq_in;
    cyc_nxt.lanes = `SBSP_LANES_NONE;
    if (snooze_request_in) begin
      // every other input is ignored; the burst context is kept for wake-up
      cyc_nxt.op = sbsp_pkg::OP_IDLE;
    end else if (!processor_addr_strobe_n_in && !chip_select_n_in) begin
      // with the primary enable low, processor strobe starts a read when sel_ok and a deselect otherwise, whatever the write lines say
      load = 1'b1;
      active_nxt = sel_ok;
      cyc_nxt.addr = addr_in;
      cyc_nxt.op = sel_ok ? sbsp_pkg::OP_READ : sbsp_pkg::OP_IDLE;
    end else if (!controller_addr_strobe_n_in) begin
      load = 1'b1;
      active_nxt = sel_ok;
      cyc_nxt.addr = addr_in;
      if (sel_ok) begin
        cyc_nxt.op = (wr_lanes != `SBSP_LANES_NONE) ? sbsp_pkg::OP_WRITE : sbsp_pkg::OP_READ;
        cyc_nxt.lanes = wr_lanes;
      end
    end else if (active_r) begin
      // advance high is a wait state: same address accessed again
      step = ~burst_advance_n_in;
      if (step) begin
        cyc_nxt.addr = {cyc_r.addr[`SBSP_ADDR_W-1:`SBSP_LO_W], burst_lo(base_lo_r, cnt_inc, linear)};
      end
      cyc_nxt.op = (wr_lanes != `SBSP_LANES_NONE) ? sbsp_pkg::OP_WRITE : sbsp_pkg::OP_READ;
      cyc_nxt.lanes = wr_lanes;
    end
  end

  // input register stage: everything is taken on the rising edge only
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      cyc_r.op <= sbsp_pkg::OP_IDLE;
      cyc_r.addr <= '0;
      cyc_r.data <= '0;
      cyc_r.lanes <= `SBSP_LANES_NONE;
      active_r <= 1'b0;
    end else begin
      cyc_r <= cyc_nxt;
      active_r <= active_nxt;
    end
  end

  // burst counter
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      base_lo_r <= `SBSP_CNT_ZERO;
      cnt_r <= `SBSP_CNT_ZERO;
    end else if (load) begin
      base_lo_r <= addr_in[`SBSP_LO_W-1:0];
      cnt_r <= `SBSP_CNT_ZERO;
    end else if (step) begin
      cnt_r <= cnt_inc;
    end
  end

  // array write: self-timed one edge after the registered cycle, per lane with its parity bit
  always_ff @(posedge ref_clk_in) begin
    if (cyc_r.op == sbsp_pkg::OP_WRITE) begin
      for (int i = 0; i < `SBSP_LANES; i++) begin
        if (cyc_r.lanes[i]) begin
          mem[cyc_r.addr][i*`SBSP_BYTE_W +: `SBSP_BYTE_W] <= cyc_r.data[i*`SBSP_BYTE_W +: `SBSP_BYTE_W];
          mem[cyc_r.addr][`SBSP_PAR_LSB+i] <= cyc_r.data[`SBSP_PAR_LSB+i];
        end
      end
    end
  end

  // array read into the output register; memory itself is not reset
  always_ff @(posedge ref_clk_in) begin
    if (cyc_r.op == sbsp_pkg::OP_READ) begin
      rdata_r <= mem[cyc_r.addr];
    end
  end

  // output drive: set by a read, dropped at the edge after a non-read cycle
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      drive_r <= 1'b0;
      rd_done_r <= 1'b0;
      snooze_r <= 1'b0;
    end else begin
      drive_r <= (cyc_r.op == sbsp_pkg::OP_READ);
      rd_done_r <= (cyc_r.op == sbsp_pkg::OP_READ);
      snooze_r <= snooze_request_in;
    end
  end

  // output enable stays asynchronous on purpose, so this one enable is not a pure flop
  assign dq_oe_out = drive_r & ~output_enable_n_in;
  assign dq_out = rdata_r;
  assign snooze_active_out = snooze_r;

  // read beats are copied to a side stream; beats are dropped while capture_ready_out is low
  sbsp_fifo #(
    .W(`SBSP_DATA_W),
    .DEPTH(`SBSP_FIFO_DEPTH),
    .AW(`SBSP_FIFO_AW)
  ) u_capture (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .in_valid_in(rd_done_r),
    .in_data_in(rdata_r),
    .in_ready_out(capture_ready_out),
    .out_valid_out(capture_valid_out),
    .out_data_out(capture_data_out),
    .out_ready_in(capture_ready_in)
  );

  sequence s_read_issued;
    cyc_r.op == sbsp_pkg::OP_READ;
  endsequence

  sequence s_then_no_read;
    ##1 cyc_r.op != sbsp_pkg::OP_READ;
  endsequence

  a_read_drives_bus: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    s_read_issued |=> drive_r && rd_done_r)
    else $error("read cycle did not reach the output register");

  a_deselect_release: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    s_read_issued ##0 s_then_no_read |=> !drive_r)
    else $error("bus not released after deselect");

  a_oe_gates_bus: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    dq_oe_out |-> !output_enable_n_in && drive_r)
    else $error("data driven without output enable");

  a_snooze_ignores: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    snooze_request_in |=> cyc_r.op == sbsp_pkg::OP_IDLE && $stable(active_r))
    else $error("input acted on during snooze");

  a_global_all_lanes: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (!snooze_request_in && !all_lanes_write_n_in && !controller_addr_strobe_n_in && sel_ok
     && processor_addr_strobe_n_in) |=> cyc_r.op == sbsp_pkg::OP_WRITE && cyc_r.lanes == `SBSP_LANES_ALL)
    else $error("global write missed a lane");

  a_gate_blocks_lanes: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (all_lanes_write_n_in && lane_write_gate_n_in) |=> cyc_r.op != sbsp_pkg::OP_WRITE)
    else $error("lane write without the byte-write gate");

  a_wait_holds_addr: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (active_r && !snooze_request_in && processor_addr_strobe_n_in && controller_addr_strobe_n_in
     && burst_advance_n_in) |=> $stable(cyc_r.addr) && $stable(cnt_r))
    else $error("address moved during a wait state");

  a_strobe_loads: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (!snooze_request_in && !controller_addr_strobe_n_in) |=> cyc_r.addr == $past(addr_in) && cnt_r == 2'h0)
    else $error("strobe did not load the address");

  a_linear_wraps: assert property (@(posedge ref_clk_in) disable iff (!resetn_in)
    (!snooze_request_in && !controller_addr_strobe_n_in && !burst_order_select_in)
    ##1 (step && !burst_order_select_in)[*3] |=> cyc_r.addr[1:0] == $past(cyc_r.addr[1:0], 3) + 2'h3)
    else $error("linear burst order wrong");
endmodule : sbsp_port

// File: include/sbsp_cfg.svh
// constants for the synchronous burst sram port
`ifndef SBSP_CFG_SVH
`define SBSP_CFG_SVH

`define SBSP_ADDR_W 19
`define SBSP_DEPTH 524288
`define SBSP_LANES 4
`define SBSP_BYTE_W 8
`define SBSP_DATA_W 36
`define SBSP_PAR_LSB 32
`define SBSP_LO_W 2
`define SBSP_LANES_ALL 4'hf
`define SBSP_LANES_NONE 4'h0
`define SBSP_CNT_ZERO 2'h0
`define SBSP_CNT_ONE 2'h1
`define SBSP_FIFO_DEPTH 16
`define SBSP_FIFO_AW 4

`endif

// File: include/sbsp_pkg.sv
// types used by the burst sram port; the capture fifo uses none of them
`include "sbsp_cfg.svh"
package sbsp_pkg;

  typedef enum logic [2:0] {
    OP_IDLE  = 3'h1,
    OP_READ  = 3'h2,
    OP_WRITE = 3'h4
  } sbsp_op_t;

  typedef struct packed {
    sbsp_op_t op;
    logic [`SBSP_ADDR_W-1:0] addr;
    logic [`SBSP_DATA_W-1:0] data;
    logic [`SBSP_LANES-1:0] lanes;
  } sbsp_cyc_t;

endpackage : sbsp_pkg

// File: verif/sbsp_master.sv
// bus master model that drives the burst sram port
`timescale 1ns/1ps
`include "sbsp_cfg.svh"
module sbsp_master (
  input wire logic ref_clk_in,
  output logic [`SBSP_ADDR_W-1:0] addr_out,
  output logic [`SBSP_DATA_W-1:0] dq_out,
  output logic [2:0] en_out,
  output logic ps_n_out,
  output logic cs_n_out,
  output logic advance_n_out,
  output logic [3:0] lane_n_out,
  output logic gate_n_out,
  output logic glob_n_out,
  output logic oe_n_out,
  output logic snooze_out,
  output logic order_out
);
  // en_out holds raw pin levels: primary low, expansion high, expansion low
  initial begin
    addr_out = '0;
    dq_out = '0;
    en_out = 3'h6;
    ps_n_out = 1'b1;
    cs_n_out = 1'b1;
    advance_n_out = 1'b1;
    lane_n_out = 4'hf;
    gate_n_out = 1'b1;
    glob_n_out = 1'b1;
    oe_n_out = 1'b0;
    snooze_out = 1'b0;
    order_out = 1'b1;
  end

  // k: 0 no strobe, 1 controller strobe, 2 processor strobe
  task cyc(input logic [1:0] k, input logic [2:0] en, input logic [3:0] ln, input logic gt,
    input logic glob, input logic advance, input logic [18:0] a, input logic [35:0] d);
    @(negedge ref_clk_in);
    ps_n_out = (k != 2'h2);
    cs_n_out = (k != 2'h1);
    en_out = en;
    lane_n_out = ln;
    gate_n_out = gt;
    glob_n_out = glob;
    advance_n_out = advance;
    addr_out = a;
    // data lines not in a write toggle, so a stale value never looks valid
    dq_out = (glob & (gt | (&ln))) ? ~dq_out : d;
  endtask : cyc
endmodule : sbsp_master

// File: verif/tb_top.sv
// self-checking bench for the burst sram port
`timescale 1ns/1ps
`include "sbsp_cfg.svh"
module tb_top;
  logic ref_clk_in, resetn_in, cap_rdy, ps_n, cs_n, advance_n, gate_n, glob_n, oe_n, snz, ord;
  logic oe, snz_act, cap_v, cap_ro;
  logic [`SBSP_ADDR_W-1:0] a;
  logic [`SBSP_DATA_W-1:0] d, rq, cap_d, v;
  logic [2:0] en;
  logic [3:0] ln;
  logic [1:0] lo;
  logic [35:0] q[$];
  logic [2:0] bad[3] = '{3'h0, 3'h3, 3'h6};
  logic [1:0] cnts[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
  int err_total, checks, n;

  sbsp_master m (.ref_clk_in(ref_clk_in), .addr_out(a), .dq_out(d), .en_out(en), .ps_n_out(ps_n),
    .cs_n_out(cs_n), .advance_n_out(advance_n), .lane_n_out(ln), .gate_n_out(gate_n), .glob_n_out(glob_n),
    .oe_n_out(oe_n), .snooze_out(snz), .order_out(ord));
  sbsp_port dut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .addr_in(a), .dq_in(d), .dq_out(rq),
    .dq_oe_out(oe), .chip_select_n_in(en[2]), .expansion_select_high_in(en[1]),
    .expansion_select_low_n_in(en[0]), .processor_addr_strobe_n_in(ps_n),
    .controller_addr_strobe_n_in(cs_n), .burst_advance_n_in(advance_n), .lane_a_write_n_in(ln[0]),
    .lane_b_write_n_in(ln[1]), .lane_c_write_n_in(ln[2]), .lane_d_write_n_in(ln[3]),
    .lane_write_gate_n_in(gate_n), .all_lanes_write_n_in(glob_n), .output_enable_n_in(oe_n),
    .snooze_request_in(snz), .burst_order_select_in(ord), .snooze_active_out(snz_act),
    .capture_valid_out(cap_v), .capture_data_out(cap_d), .capture_ready_in(cap_rdy),
    .capture_ready_out(cap_ro));

  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  task chk(input string nm, input logic [35:0] s, input logic [35:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task end_sim;
    $display("mismatches %0d comparisons %0d", err_total, checks);
    if (err_total == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  function automatic logic [35:0] mrg(input logic [35:0] o, input logic [35:0] w, input logic [3:0] k);
    logic [35:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (k[i]) begin
        r[8*i +: 8] = w[8*i +: 8];
        r[32+i] = w[32+i];
      end
    end
    return r;
  endfunction : mrg

  // deselect cycle: controller strobe with the primary enable high, ends any burst
  task des;
    m.cyc(2'h1, 3'h6, 4'hf, 1'b1, 1'b1, 1'b1, '0, '0);
  endtask : des

  task wr(input logic [3:0] l, input logic gt, input logic glob, input logic [18:0] ad, input logic [35:0] dt);
    m.cyc(2'h1, 3'h2, l, gt, glob, 1'b1, ad, dt);
    des();
  endtask : wr

  task rd(input logic [1:0] k, input logic [2:0] e, input logic [18:0] ad, input logic [35:0] x);
    m.cyc(k, e, 4'hf, 1'b1, 1'b1, 1'b1, ad, '0);
    des();
    des();
    chk("drive", 36'(oe), 36'(e == 3'h2));
    if (e == 3'h2) chk("rdata", rq, x);
    m.oe_n_out = 1'b1;
    #1 chk("oe_gate", 36'(oe), 36'h0);
    des();
    m.oe_n_out = 1'b0;
    des();
    chk("release", 36'(oe), 36'h0);
  endtask : rd

  initial begin
    repeat (20000) @(posedge ref_clk_in);
    err_total++;
    end_sim();
  end

  initial begin
    resetn_in = 1'b0;
    cap_rdy = 1'b1;
    repeat (8) @(negedge ref_clk_in);
    resetn_in = 1'b1;
    chk("rst", {oe, cap_v, cap_ro, snz_act}, 36'h2);
    v = 36'h5a5a5a5a5;
    wr(4'hf, 1'b1, 1'b0, 19'h10, v);
    rd(2'h1, 3'h2, 19'h10, v);
    for (int i = 0; i < 4; i++) begin
      wr(4'(~(4'h1 << i)), 1'b0, 1'b1, 19'h10, ~v);
      v = mrg(v, ~v, 4'(4'h1 << i));
      rd(2'h1, 3'h2, 19'h10, v);
    end
    wr(4'h0, 1'b1, 1'b1, 19'h10, ~v);
    rd(2'h1, 3'h2, 19'h10, v);
    wr(4'he, 1'b0, 1'b0, 19'h10, ~v);
    v = ~v;
    rd(2'h2, 3'h2, 19'h10, v);
    for (int k = 1; k < 3; k++) foreach (bad[j]) rd(2'(k), bad[j], 19'h10, '0);
    for (int o = 0; o < 2; o++) begin
      m.order_out = 1'(o);
      for (int i = 0; i < 4; i++) wr(4'hf, 1'b1, 1'b0, 19'h40 + 19'(i), 36'(o * 4 + i + 7));
      m.cyc(2'h1, 3'h2, 4'hf, 1'b1, 1'b1, 1'b1, 19'h43, '0);
      // three steps then a wait, so a whole four-beat wrap is walked in either order before the held beat
      for (int b = 0; b < 6; b++) begin
        if (b < 4) m.cyc(2'h0, 3'h2, 4'hf, 1'b1, 1'b1, 1'(b == 3), '0, '0);
        else des();
        if (b > 0) begin
          lo = (o == 1) ? (2'h3 ^ cnts[b - 1]) : (2'h3 + cnts[b - 1]);
          chk("burst", rq, 36'(o * 4 + lo + 7));
        end
      end
    end
    m.snooze_out = 1'b1;
    des();
    des();
    chk("snooze", 36'(snz_act), 36'h1);
    wr(4'hf, 1'b1, 1'b0, 19'h10, ~v);
    m.snooze_out = 1'b0;
    des();
    des();
    chk("wake", 36'(snz_act), 36'h0);
    rd(2'h1, 3'h2, 19'h10, v);
    // fill the capture fifo with the far side stalled until it refuses
    // one more edge lets the wake-up read beat leave the output stage first
    @(negedge ref_clk_in);
    cap_rdy = 1'b0;
    for (int i = 0; i < 18; i++) begin
      q.push_back(36'(4 + (i % 4) + 7));
      rd(2'h1, 3'h2, 19'h40 + 19'(i % 4), q[i]);
    end
    chk("full", 36'(cap_ro), 36'h0);
    n = 0;
    for (int t = 0; t < 60; t++) begin
      @(negedge ref_clk_in);
      cap_rdy = 1'(t % 2);
      if (cap_v && cap_rdy && n < 18) begin
        chk("beat", cap_d, q[n]);
        n++;
      end
    end
    chk("beats", 36'(n), 36'd17);
    chk("empty", {cap_v, cap_ro}, 36'h1);
    end_sim();
  end
endmodule : tb_top
